//--- hdl/rcs_pkg.sv
// package: constants, register map and types for the reset cause and clock select block
package rcs_pkg;

  // clock rate and documented delays (ns); counts round up to whole cycles
  localparam int unsigned CLK_MHZ        = 40;
  localparam int unsigned POR_DELAY_NS   = 10000;
  localparam int unsigned POWER_UP_TIMER_DELAY_NS  = 2000;
  localparam int unsigned OST_DELAY_NS   = 4000;
  localparam int unsigned PLL_LOCK_NS    = 20000;
  localparam int unsigned FAIL_SAFE_CLOCK_MONITOR_DELAY_NS  = 500;
  localparam int unsigned POR_CYC  = (POR_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned POWER_UP_TIMER_CYC = (POWER_UP_TIMER_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned OST_CYC  = (OST_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PLL_CYC  = (PLL_LOCK_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned FAIL_SAFE_CLOCK_MONITOR_CYC = (FAIL_SAFE_CLOCK_MONITOR_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W    = 16;
  localparam logic [CNT_W-1:0] RST_DLY  = CNT_W'(POR_CYC + POWER_UP_TIMER_CYC);
  localparam logic [CNT_W-1:0] OST_DLY  = CNT_W'(OST_CYC);
  localparam logic [CNT_W-1:0] PLL_DLY  = CNT_W'(PLL_CYC);
  localparam logic [CNT_W-1:0] FAIL_SAFE_CLOCK_MONITOR_DLY = CNT_W'(FAIL_SAFE_CLOCK_MONITOR_CYC);
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

  // register byte offsets on the wishbone bus
  localparam logic [7:0] OFS_CAUSE    = 8'h00;
  localparam logic [7:0] OFS_OSC      = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h10;

  // reset cause status bit positions
  localparam int unsigned B_TRAP  = 15;
  localparam int unsigned B_ILL   = 14;
  localparam int unsigned B_EXT   = 7;
  localparam int unsigned B_SWR   = 6;
  localparam int unsigned B_WATCHDOG_TIMEOUT_FLAG  = 4;
  localparam int unsigned B_SLEEP = 3;
  localparam int unsigned B_IDLE  = 2;
  localparam int unsigned B_BOR   = 1;
  localparam int unsigned B_POR   = 0;
  localparam logic [15:0] CAUSE_MASK  = 16'hC0DF;
  localparam logic [15:0] CAUSE_RST   = 16'h0003;
  localparam logic [15:0] CAUSE_ZERO  = 16'h0000;

  // oscillator status register fields
  localparam int unsigned OSC_CUR_LSB  = 12;
  localparam int unsigned OSC_CFG_LSB  = 8;
  localparam int unsigned OSC_SWEN_BIT = 7;
  localparam int unsigned OSC_FAIL_SAFE_CLOCK_MONITOR_BIT = 2;
  localparam int unsigned OSC_RUN_BIT  = 1;
  localparam int unsigned OSC_RST_BIT  = 0;
  localparam logic [2:0]  OSC_RST      = 3'h0;

  // interrupt status bits
  localparam int unsigned IRQ_W     = 4;
  localparam int unsigned IRQ_REL   = 0;
  localparam int unsigned IRQ_RUN   = 1;
  localparam int unsigned IRQ_FAIL_SAFE_CLOCK_MONITOR  = 2;
  localparam int unsigned IRQ_CAUSE = 3;

  // one-cycle event pulses from the core and the reset sources
  typedef struct packed {
    logic por;
    logic bor;
    logic pin_rst;
    logic wdt_rst;
    logic sw_rst;
    logic trap;
    logic illegal;
    logic wdt_expire;
    logic sav_sleep;
    logic sav_idle;
  } rcs_evt_t;

  // reset release sequence
  typedef enum logic [2:0] {
    SEQ_HOLD = 3'b001,
    SEQ_OSC  = 3'b010,
    SEQ_RUN  = 3'b100
  } rcs_seq_t;

endpackage

//--- hdl/rcs_top.sv
// module: reset cause recording, post-reset clock select and reset release sequencing
//
// Overview of operation
// - A trap conflict sets bit 15, and only a power-on or brown-out reset clears it.
// - An illegal opcode or uninitialised register address sets bit 14, cleared by power-on or brown-out.
// - A master clear pin reset sets bit 7, cleared only by power-on and kept through brown-out.
// - A reset instruction sets bit 6, cleared by power-on or brown-out.
// - A watchdog expiry sets bit 4, cleared by a power-save instruction, power-on or brown-out.
// - A sleep power-save instruction sets bit 3, cleared by power-on or brown-out.
// - An idle power-save instruction sets bit 2, cleared by power-on or brown-out.
// - A brown-out or power-on reset sets bit 1, and no hardware event clears it.
// - Only a power-on reset sets bit 0, and no hardware event clears it.
// - Software may write every cause flag to one or zero besides the hardware events.
// - With clock switching off the clock after any reset comes from the configuration field.
// - With switching on, power-on and brown-out use the configuration field, other resets keep bits 14:12.
// - System reset stays asserted until the power-on and power-up timer delays have both run.
// - Start-up timer and lock wait run alongside the reset delays, and code runs after both.
// - Clock fail monitoring starts a further monitor delay after the system reset release.
//
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
module rcs_top
  import rcs_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // reset sources and core events
  input  wire rcs_evt_t    evt_i,
  // oscillator configuration
  input  wire logic        clk_switch_en_i,
  input  wire logic [2:0]  initial_osc_config_field_i,
  input  wire logic        pll_used_i,
  // sequencing and clock outputs
  output logic             sys_reset_o,
  output logic             code_run_o,
  output logic             fail_safe_clock_monitor_active_o,
  output logic      [2:0]  clk_src_o,
  // interrupt
  output logic             irq_o
);

  // bus and register state
  logic             ack_r;
  logic [31:0]      dat_r;
  logic [15:0]      cause_r;
  logic [15:0]      cause_nxt;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_stat_nxt;
  logic [IRQ_W-1:0] irq_en_r;
  logic             irq_r;
  // sequencer state
  rcs_seq_t         seq_r;
  logic [CNT_W-1:0] rst_cnt_r;
  logic [CNT_W-1:0] osc_cnt_r;
  logic [CNT_W-1:0] fail_safe_clock_monitor_cnt_r;
  logic             rst_done_r;
  logic             osc_done_r;
  logic             fail_safe_clock_monitor_r;
  logic             por_pend_r;
  logic [2:0]       current_osc_field_r;
  // combinational helpers
  logic             wr_en;
  logic             is_por;
  logic             is_bor;
  logic             any_rst;
  logic             rel_evt;
  logic             run_evt;
  logic             fail_safe_clock_monitor_evt;
  logic [15:0]      set_vec;
  logic [15:0]      clr_vec;
  logic [15:0]      wr_val;
  logic [31:0]      rd_val;
  logic [15:0]      osc_view;

  // a write takes effect on the edge at which ack is seen high
  // so a request held through its ack writes exactly once
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;

  // reset kinds; the clocked reset input becomes a power-on event one cycle later
  // trap and illegal events restart the release sequence like the other resets
  // watchdog expiry and power-save events only touch flags
  assign is_por  = evt_i.por | por_pend_r;
  assign is_bor  = evt_i.bor;
  assign any_rst = is_por | is_bor | evt_i.pin_rst | evt_i.wdt_rst | evt_i.sw_rst
                 | evt_i.trap | evt_i.illegal;

  // hardware set events per cause flag
  // each bit is a one-cycle pulse; the flag itself holds the history
  always_comb begin
    set_vec          = CAUSE_ZERO;
    set_vec[B_TRAP]  = evt_i.trap;
    set_vec[B_ILL]   = evt_i.illegal;
    set_vec[B_EXT]   = evt_i.pin_rst;
    set_vec[B_SWR]   = evt_i.sw_rst;
    set_vec[B_WATCHDOG_TIMEOUT_FLAG]  = evt_i.wdt_expire;
    set_vec[B_SLEEP] = evt_i.sav_sleep;
    set_vec[B_IDLE]  = evt_i.sav_idle;
    set_vec[B_BOR]   = is_bor | is_por;
    set_vec[B_POR]   = is_por;
  end

  // hardware clear events; flags not named here survive any reset
  // brown-out keeps the pin reset flag, so a pin reset stays visible afterwards
  always_comb begin
    clr_vec          = CAUSE_ZERO;
    clr_vec[B_TRAP]  = is_por | is_bor;
    clr_vec[B_ILL]   = is_por | is_bor;
    clr_vec[B_EXT]   = is_por;
    clr_vec[B_SWR]   = is_por | is_bor;
    clr_vec[B_WATCHDOG_TIMEOUT_FLAG]  = is_por | is_bor | evt_i.sav_sleep | evt_i.sav_idle;
    clr_vec[B_SLEEP] = is_por | is_bor;
    clr_vec[B_IDLE]  = is_por | is_bor;
  end

  // software write value with byte lanes; unimplemented bits stay zero
  always_comb begin
    wr_val = cause_r;
    if (wb_sel_i[0]) begin
      wr_val[7:0] = wb_dat_i[7:0];
    end
    if (wb_sel_i[1]) begin
      wr_val[15:8] = wb_dat_i[15:8];
    end
    wr_val = wr_val & CAUSE_MASK;
  end

  // next flags: software write first, then hardware clear, hardware set wins last
  // an event in the same cycle as a software write is never lost
  always_comb begin
    cause_nxt = cause_r;
    if (wr_en && wb_adr_i == OFS_CAUSE) begin
      cause_nxt = wr_val;
    end
    cause_nxt = ((cause_nxt & ~clr_vec) | set_vec) & CAUSE_MASK;
  end

  // reset cause status register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause_r <= CAUSE_RST;
    end else begin
      cause_r <= cause_nxt;
    end
  end

  // a synchronous reset is replayed as a power-on event on the next cycle
  // this loads the clock source and restarts every delay without a second path
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      por_pend_r <= 1'b1;
    end else begin
      por_pend_r <= 1'b0;
    end
  end

  // post-reset clock source choice
  // only reset events move the source; between resets it never changes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      current_osc_field_r <= OSC_RST;
    end else if (any_rst) begin
      if (!clk_switch_en_i) begin
        current_osc_field_r <= initial_osc_config_field_i;
      end else if (is_por || is_bor) begin
        current_osc_field_r <= initial_osc_config_field_i;
      end else begin
        current_osc_field_r <= current_osc_field_r;
      end
    end
  end

  // release sequence: hold reset, wait oscillator, run
  // a new reset event drops back to hold from any state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_r <= SEQ_HOLD;
    end else if (any_rst) begin
      seq_r <= SEQ_HOLD;
    end else begin
      case (seq_r)
        SEQ_HOLD: begin
          if (rst_done_r) begin
            seq_r <= osc_done_r ? SEQ_RUN : SEQ_OSC;
          end
        end
        SEQ_OSC: begin
          if (osc_done_r) begin
            seq_r <= SEQ_RUN;
          end
        end
        SEQ_RUN: begin
          seq_r <= SEQ_RUN;
        end
        default: begin
          seq_r <= SEQ_HOLD;
        end
      endcase
    end
  end

  // power-on plus power-up timer delay counter
  // counts to one and then parks at zero, so done stays high until a reset
  always_ff @(posedge clk_i) begin
    if (rst_i || any_rst) begin
      rst_cnt_r  <= RST_DLY;
      rst_done_r <= 1'b0;
    end else if (rst_cnt_r > CNT_ONE) begin
      rst_cnt_r <= rst_cnt_r - CNT_ONE;
    end else begin
      rst_cnt_r  <= CNT_ZERO;
      rst_done_r <= 1'b1;
    end
  end

  // start-up timer and lock wait, running alongside the reset delay
  // the lock wait is chosen at the reset event; later changes wait for the next reset
  always_ff @(posedge clk_i) begin
    if (rst_i || any_rst) begin
      osc_cnt_r  <= pll_used_i ? CNT_W'(OST_DLY + PLL_DLY) : OST_DLY;
      osc_done_r <= 1'b0;
    end else if (osc_cnt_r > CNT_ONE) begin
      osc_cnt_r <= osc_cnt_r - CNT_ONE;
    end else begin
      osc_cnt_r  <= CNT_ZERO;
      osc_done_r <= 1'b1;
    end
  end

  // clock monitor delay, counted from the system reset release
  // it stays frozen while held in reset, so the delay never overlaps the hold
  always_ff @(posedge clk_i) begin
    if (rst_i || any_rst) begin
      fail_safe_clock_monitor_cnt_r <= FAIL_SAFE_CLOCK_MONITOR_DLY;
      fail_safe_clock_monitor_r     <= 1'b0;
    end else if (seq_r != SEQ_HOLD) begin
      if (fail_safe_clock_monitor_cnt_r > CNT_ONE) begin
        fail_safe_clock_monitor_cnt_r <= fail_safe_clock_monitor_cnt_r - CNT_ONE;
      end else begin
        fail_safe_clock_monitor_cnt_r <= CNT_ZERO;
        fail_safe_clock_monitor_r     <= 1'b1;
      end
    end
  end

  // sequencing outputs from flip-flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_reset_o   <= 1'b1;
      code_run_o    <= 1'b0;
      fail_safe_clock_monitor_active_o <= 1'b0;
      clk_src_o     <= OSC_RST;
    end else begin
      sys_reset_o   <= (seq_r == SEQ_HOLD);
      code_run_o    <= (seq_r == SEQ_RUN);
      fail_safe_clock_monitor_active_o <= fail_safe_clock_monitor_r;
      clk_src_o     <= current_osc_field_r;
    end
  end

  // interrupt events: two cycles before the sys_reset_o and code_run_o edges, one cycle before the monitor output edge
  // each fires once per release, since the sequence leaves its state at once
  assign rel_evt  = (seq_r == SEQ_HOLD) & rst_done_r & ~any_rst;
  assign run_evt  = (seq_r != SEQ_RUN) & rst_done_r & osc_done_r & ~any_rst;
  assign fail_safe_clock_monitor_evt = fail_safe_clock_monitor_r & ~fail_safe_clock_monitor_active_o;

  // sticky interrupt status; a new event wins over a clear in the same cycle
  always_comb begin
    irq_stat_nxt = irq_stat_r;
    if (wr_en && wb_adr_i == OFS_IRQ_CLR) begin
      irq_stat_nxt = irq_stat_nxt & ~wb_dat_i[IRQ_W-1:0];
    end
    irq_stat_nxt[IRQ_REL]   = irq_stat_nxt[IRQ_REL] | rel_evt;
    irq_stat_nxt[IRQ_RUN]   = irq_stat_nxt[IRQ_RUN] | run_evt;
    irq_stat_nxt[IRQ_FAIL_SAFE_CLOCK_MONITOR]  = irq_stat_nxt[IRQ_FAIL_SAFE_CLOCK_MONITOR] | fail_safe_clock_monitor_evt;
    irq_stat_nxt[IRQ_CAUSE] = irq_stat_nxt[IRQ_CAUSE] | (|(set_vec & ~cause_r));
  end

  // interrupt status, enable and output
  // the output is registered, so it follows status and enable one cycle late
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= '0;
      irq_en_r   <= '0;
      irq_r      <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      if (wr_en && wb_adr_i == OFS_IRQ_EN) begin
        irq_en_r <= wb_dat_i[IRQ_W-1:0];
      end
      irq_r <= |(irq_stat_r & irq_en_r);
    end
  end
  assign irq_o = irq_r;

  // oscillator and sequence status view
  // the configuration field and switch enable are shown as they stand at the pins
  always_comb begin
    osc_view                                  = CAUSE_ZERO;
    osc_view[OSC_CUR_LSB+2:OSC_CUR_LSB]       = current_osc_field_r;
    osc_view[OSC_CFG_LSB+2:OSC_CFG_LSB]       = initial_osc_config_field_i;
    osc_view[OSC_SWEN_BIT]                    = clk_switch_en_i;
    osc_view[OSC_FAIL_SAFE_CLOCK_MONITOR_BIT]                    = fail_safe_clock_monitor_active_o;
    osc_view[OSC_RUN_BIT]                     = code_run_o;
    osc_view[OSC_RST_BIT]                     = sys_reset_o;
  end

  // read mux; unmapped and write-only offsets read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    case (wb_adr_i)
      OFS_CAUSE:    rd_val[15:0]      = cause_r;
      OFS_OSC:      rd_val[15:0]      = osc_view;
      OFS_IRQ_STAT: rd_val[IRQ_W-1:0] = irq_stat_r;
      OFS_IRQ_EN:   rd_val[IRQ_W-1:0] = irq_en_r;
      default:      rd_val            = 32'h0000_0000;
    endcase
  end

  // wishbone handshake: ack one cycle after the request, dropped the cycle after
  // read data is captured with the ack so it stands until the next read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
      if (wb_cyc_i && wb_stb_i && !ack_r && !wb_we_i) begin
        dat_r <= rd_val;
      end
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

endmodule

//--- testbench/rcs_top_sva.sv
// checker: bus handshake, release sequencing and clock select properties
`timescale 1ns/1ps
module rcs_top_sva
  import rcs_pkg::*;
(
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // bus handshake
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  // events and configuration
  input wire rcs_evt_t   evt_i,
  input wire logic       clk_switch_en_i,
  input wire logic [2:0] initial_osc_config_field_i,
  input wire logic       pll_used_i,
  // sequencing outputs
  input wire logic       sys_reset_o,
  input wire logic       code_run_o,
  input wire logic       fail_safe_clock_monitor_active_o,
  input wire logic [2:0] clk_src_o
);
  logic [15:0] cnt_r;
  logic        pll_r;
  logic        keep_evt;
  logic        rst_evt;

  // resets that keep the current source, and all restarts
  assign keep_evt = evt_i.pin_rst | evt_i.wdt_rst | evt_i.sw_rst | evt_i.trap | evt_i.illegal;
  assign rst_evt  = evt_i.por | evt_i.bor | keep_evt;

  // cycles since the last restart, saturating; lock wait noted at the restart
  always_ff @(posedge clk_i) begin
    if (rst_i || rst_evt) begin
      cnt_r <= 16'h0000;
      pll_r <= pll_used_i;
    end else if (cnt_r != 16'hFFFF) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_cfg_evt;
    evt_i.por || evt_i.bor || (keep_evt && !clk_switch_en_i);
  endsequence

  property p_ack_resp;   s_req |=> wb_ack_o; endproperty
  property p_ack_pulse;  wb_ack_o |=> !wb_ack_o; endproperty
  property p_rst_rise;   rst_evt |-> ##[1:3] sys_reset_o; endproperty
  property p_rst_hold;   $fell(sys_reset_o) |-> cnt_r >= RST_DLY; endproperty
  property p_run_wait;
    $rose(code_run_o) |-> cnt_r >= RST_DLY && cnt_r >= OST_DLY + (pll_r ? PLL_DLY : CNT_ZERO);
  endproperty
  property p_run_rel;    $rose(code_run_o) |-> !sys_reset_o; endproperty
  property p_fail_safe_clock_monitor_wait;
    $rose(fail_safe_clock_monitor_active_o) |-> !sys_reset_o && cnt_r >= RST_DLY + FAIL_SAFE_CLOCK_MONITOR_DLY;
  endproperty
  property p_fail_safe_clock_monitor_late;  $fell(sys_reset_o) |-> !fail_safe_clock_monitor_active_o [*8]; endproperty
  property p_clk_cfg;
    s_cfg_evt |-> ##[1:3] (clk_src_o == initial_osc_config_field_i);
  endproperty
  property p_clk_keep;   keep_evt && clk_switch_en_i |=> $stable(clk_src_o) [*3]; endproperty

  a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_rst_rise: assert property (p_rst_rise) else $error("reset not asserted");
  a_rst_hold: assert property (p_rst_hold) else $error("reset released early");
  a_run_wait: assert property (p_run_wait) else $error("code run too early");
  a_run_rel: assert property (p_run_rel) else $error("code run under reset");
  a_fail_safe_clock_monitor_wait: assert property (p_fail_safe_clock_monitor_wait) else $error("monitor started early");
  a_fail_safe_clock_monitor_late: assert property (p_fail_safe_clock_monitor_late) else $error("monitor at release");
  a_clk_cfg: assert property (p_clk_cfg) else $error("source not from config");
  a_clk_keep: assert property (p_clk_keep) else $error("source not kept");
endmodule

bind rcs_top rcs_top_sva u_rcs_top_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .evt_i, .clk_switch_en_i, .initial_osc_config_field_i, .pll_used_i, .sys_reset_o,
  .code_run_o, .fail_safe_clock_monitor_active_o, .clk_src_o);

//--- testbench/testbench.sv
// testbench: cause flags, interrupt, clock select and release sequence
`timescale 1ns/1ps
module testbench
  import rcs_pkg::*;
();
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, clk_switch_en_i, pll_used_i;
  logic        wb_ack_o, sys_reset_o, code_run_o, fail_safe_clock_monitor_active_o, irq_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [2:0]  initial_osc_config_field_i, clk_src_o, cur;
  rcs_evt_t    evt_i;
  logic [31:0] exp_q[$];
  int          failures, num_checks, cyc_n;
  localparam logic [15:0] PRE_T [14] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
    16'hC0DF, 16'hC0DF, 16'hC0DF, 16'hC0DF, 16'hC0DF, 16'hC0DF, 16'h0};
  localparam logic [9:0] EV_T [14] = '{10'h010, 10'h008, 10'h080, 10'h020, 10'h004,
    10'h002, 10'h001, 10'h100, 10'h200, 10'h002, 10'h001, 10'h080, 10'h040, 10'h100};
  localparam logic [15:0] EX_T [14] = '{16'h8000, 16'h4000, 16'h0080, 16'h0040, 16'h0010,
    16'h0008, 16'h0004, 16'h0083, 16'h0003, 16'hC0CF, 16'hC0CF, 16'hC0DF, 16'hC0DF, 16'h0002};
  localparam logic [9:0] CK_T [8] = '{10'h200, 10'h080, 10'h080, 10'h040, 10'h020, 10'h100,
    10'h020, 10'h010};
  localparam logic [7:0] SW_T = 8'hBB;

  // device under test
  rcs_top u_rcs_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .evt_i, .clk_switch_en_i, .initial_osc_config_field_i,
    .pll_used_i, .sys_reset_o, .code_run_o, .fail_safe_clock_monitor_active_o, .clk_src_o, .irq_o);

  // 40 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // read data against the oldest noted expectation
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
      check("rd_data", exp_q.pop_front(), wb_dat_o);
    end
  end

  // hang limit
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 30000) begin
      failures++;
      report_and_stop();
    end
  end

  // one classic bus cycle, held until ack is sampled
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] s);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    // no local limit: only the hang limit ends this wait
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_cycle(1'b1, a, d, 4'hF);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb_cycle(1'b0, a, 32'h0, 4'hF);
  endtask

  // one-cycle event pulse
  task automatic pulse(input logic [9:0] e);
    @(posedge clk_i);
    evt_i <= rcs_evt_t'(e);
    @(posedge clk_i);
    evt_i <= rcs_evt_t'(10'h000);
  endtask

  // wait for code run and clock monitoring
  task automatic wait_run();
    int n;
    n = 0;
    repeat (4) @(posedge clk_i);
    while (!(code_run_o === 1'b1 && fail_safe_clock_monitor_active_o === 1'b1) && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 3000) failures++;
  endtask

  task automatic irq_is(input logic v);
    repeat (3) @(posedge clk_i);
    check("irq", {31'h0, v}, {31'h0, irq_o});
  endtask

  // main sequence
  initial begin
    logic [31:0] rv;
    logic [2:0]  c;
    {rst_i, clk_switch_en_i} = 2'b11;
    {wb_cyc_i, wb_stb_i, wb_we_i, pll_used_i} = 4'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    initial_osc_config_field_i = 3'h5;
    evt_i = rcs_evt_t'(10'h000);
    {failures, num_checks, cyc_n} = '0;
    rv = $urandom(32'h9334);
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_CAUSE, 32'h0003);
    wait_run();
    check("clk_src", 32'h5, {29'h0, clk_src_o});
    rd(OFS_OSC, 32'h5586);
    cur = 3'h5;
    $display("test reset done");
    for (int i = 0; i < 14; i++) begin
      wr(OFS_CAUSE, {16'h0, PRE_T[i]});
      pulse(EV_T[i]);
      rd(OFS_CAUSE, {16'h0, EX_T[i]});
    end
    rv = $urandom();
    wr(OFS_CAUSE, rv);
    rd(OFS_CAUSE, rv & {16'h0, CAUSE_MASK});
    wr(OFS_CAUSE, 32'h0);
    wb_cycle(1'b1, OFS_CAUSE, 32'hFFFF, 4'h2);
    rd(OFS_CAUSE, 32'hC000);
    wr(8'h40, 32'hFFFF);
    rd(8'h40, 32'h0);
    rd(OFS_IRQ_CLR, 32'h0);
    wait_run();
    $display("test cause done");
    wr(OFS_CAUSE, 32'h0);
    wr(OFS_IRQ_CLR, 32'hF);
    wr(OFS_IRQ_EN, 32'h8);
    pulse(10'h010);
    irq_is(1'b1);
    rd(OFS_IRQ_STAT, 32'h8);
    rd(OFS_OSC, 32'h5581);
    rd(OFS_IRQ_EN, 32'h8);
    wr(OFS_IRQ_EN, 32'h0);
    irq_is(1'b0);
    wr(OFS_IRQ_EN, 32'h8);
    irq_is(1'b1);
    wr(OFS_IRQ_CLR, 32'h8);
    irq_is(1'b0);
    wait_run();
    rd(OFS_IRQ_STAT, 32'h7);
    wr(OFS_IRQ_CLR, 32'hF);
    $display("test irq done");
    for (int i = 0; i < 8; i++) begin
      c = 3'($urandom());
      initial_osc_config_field_i <= c;
      clk_switch_en_i <= SW_T[i];
      pll_used_i <= i[0];
      pulse(CK_T[i]);
      if (CK_T[i][9] || CK_T[i][8] || !SW_T[i]) cur = c;
      wait_run();
      check("clk_src", {29'h0, cur}, {29'h0, clk_src_o});
      rd(OFS_OSC, {17'h0, cur, 1'b0, c, SW_T[i], 7'h06});
    end
    $display("test clock done");
    report_and_stop();
  end
endmodule
